// ===== rtl/mcd_codec.sv
// Manchester encoder and decoder between the MAC and the medium pairs.
// Assumes a 200 MHz clk; osc_input and all pins are synchronous to it.
//
// Overview of operation
// (RULE1) Bit clock is the 20 MHz reference divided by two, shared by receive.
// (RULE2) Transmit data and request are registered at each bit start.
// (RULE3) While requested, every bit is Manchester coded back to back.
// (RULE4) Without request the pair idles at zero or logical high per select.
// (RULE5) Acquisition starts after carrier is accepted and needs a 1010 pattern.
// (RULE6) Idle phase follows transmit clock; locks to second zero within 4 bits.
// (RULE7) Recovered clock starts a quarter bit into cell 5, data a quarter bit into cell 6.
// (RULE8) Recovered data rests high while idle with no recovered clock.
// (RULE9) First clock edge samples bit 5; it appears on data in cell 6.
// (RULE10) Sample a quarter bit into each cell; present at next recovered clock.
// (RULE11) Phase correction per cell is at most 10% of the measured error.
// (RULE12) Carrier sense drops 1 to 2 bit times after the last edge of either direction.
// (RULE13) Last bit still delivered; nothing delivered after the message end.
// (RULE14) After carrier drops, reassertion is blocked for at least 2 bit times.
// (RULE15) Short noise pulses are filtered before carrier detect and decoding.
// (RULE16) Mid-cell rising edge is a one, falling edge a zero.
`timescale 1ns/1ps
module mcd_codec #(
  parameter int NOISE_W = mcd_pkg::NOISE_CYC,
  parameter int DEPTH   = mcd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Reference and mode
  input  wire logic         osc_input,
  input  wire logic         tx_idle_select,
  // Controller transmit side
  input  wire logic         tx_serial_data_in,
  input  wire logic         tx_request,
  // Controller receive side
  input  wire logic         rx_ready,
  output mcd_pkg::mcd_rx_out_t rx_out,
  // Medium
  input  wire logic         rx_diff_in,
  output mcd_pkg::mcd_tx_diff_t tx_diff
);
  import mcd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             osc_q;
    logic             tx_half;
    logic [CNT_W-1:0] tx_pos;
    logic             tx_act;
    logic             tx_bit;
    logic             tx_p;
    logic             tx_n;
    logic             f_q;
    mcd_rx_st_t       st;
    logic [PH_W-1:0]  ph;
    logic [CNT_W-1:0] acq;
    logic             clk_en;
    logic             crs;
    logic [CNT_W-1:0] quiet;
    logic [CNT_W-1:0] hold;
    logic             rclk;
    logic             rdata;
    logic             ovf;
  } mcd_st_t;

  mcd_st_t          s_r;
  mcd_st_t          s_nxt;
  logic             filt;
  logic             osc_rise;
  logic             bit_start;
  logic             f_rise;
  logic             f_fall;
  logic             tick;
  logic             cen_edge;
  logic             drop;
  logic [4:0]       ph_int;
  logic [4:0]       nph_int;
  int               err;
  int               corr;
  int               ph_acc;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic             fifo_dout;

  // ----------------------------------------------------------------
  // Phase helpers
  // ----------------------------------------------------------------
  // Signed distance of a phase from the cell centre
  function automatic int ph_err(input logic [PH_W-1:0] p);
    int v;
    v = int'(p);
    return (v < PH_WRAP / 2) ? v : v - PH_WRAP;
  endfunction

  // Loop gain 3/32 stays under one tenth of the error
  // Rounds toward zero; a floored shift overshoots small negative errors
  function automatic int ph_corr(input int e);
    int m;
    m = (((e < 0) ? -e : e) * CORR_MUL) >>> CORR_SH;
    return (e < 0) ? -m : m;
  endfunction

  function automatic logic [4:0] ph_whole(input logic [PH_W-1:0] p);
    return p[PH_W-1:PH_FB];
  endfunction

  function automatic int iabs(input int v);
    return (v < 0) ? -v : v;
  endfunction

  // ----------------------------------------------------------------
  // Input filter and FIFO
  // ----------------------------------------------------------------
  mcd_noise_filter #(.N(NOISE_W)) u_filt (
    .clk  (clk),
    .rst  (rst),
    .din  (rx_diff_in),
    .dout (filt)
  );

  // Decoded bits queue here so a stalled controller loses nothing short
  mcd_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (drop),
    .in_valid  (tick),
    .in_ready  (fifo_in_ready),
    .in_data   (!filt),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_dout)
  );

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign osc_rise  = osc_input && !s_r.osc_q;
  assign bit_start = osc_rise && s_r.tx_half; // RULE1
  assign f_rise    = filt && !s_r.f_q;
  assign f_fall    = !filt && s_r.f_q;
  assign ph_int    = ph_whole(s_r.ph);
  assign err       = ph_err(s_r.ph);
  assign cen_edge  = (s_r.st == MCD_LOCK) && f_fall && (iabs(err) <= TRK_WIN);
  assign corr      = cen_edge ? ph_corr(err) : 0;
  assign ph_acc    = int'(s_r.ph) + PH_ONE - corr;
  assign nph_int   = ph_whole(PH_W'((ph_acc >= PH_WRAP) ? ph_acc - PH_WRAP : ph_acc));
  assign tick      = (s_r.st == MCD_LOCK) && (nph_int == 5'(SAMP_CYC))
                     && (ph_int != 5'(SAMP_CYC));
  assign drop      = s_r.crs && !f_rise && !f_fall
                     && (s_r.quiet >= CNT_W'(CRS_OFF_CYC - 1));
  assign fifo_out_ready = tick && s_r.clk_en && rx_ready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.osc_q = osc_input;
    s_nxt.f_q = filt;

    // Transmit divider and encoder
    if (osc_rise)
      s_nxt.tx_half = !s_r.tx_half;
    if (bit_start)
      s_nxt.tx_pos = '0;
    else if (s_r.tx_pos != CNT_W'(BIT_CYC - 1))
      s_nxt.tx_pos = s_r.tx_pos + 1'b1;
    if (bit_start)
    begin
      s_nxt.tx_act = tx_request; // RULE2
      s_nxt.tx_bit = tx_serial_data_in; // RULE2
    end
    if (s_r.tx_act)
    begin
      s_nxt.tx_p = s_r.tx_half ? s_r.tx_bit : !s_r.tx_bit; // RULE3 RULE16
      s_nxt.tx_n = s_r.tx_half ? !s_r.tx_bit : s_r.tx_bit; // RULE16
    end
    else
    begin
      s_nxt.tx_p = tx_idle_select; // RULE4
      s_nxt.tx_n = 1'b0; // RULE4
    end

    // Carrier timers
    if (s_r.hold != '0)
      s_nxt.hold = s_r.hold - 1'b1;
    // Any edge restarts it: a 1-0-1 run leaves two bit times between rises
    if (f_rise || f_fall)
      s_nxt.quiet = '0;
    else if (s_r.quiet != '1)
      s_nxt.quiet = s_r.quiet + 1'b1;

    // Acquisition and tracking
    unique case (s_r.st)
      MCD_IDLE:
      begin
        // Free-run on the transmit bit clock, centre at mid cell
        s_nxt.ph = (s_r.tx_pos >= CNT_W'(HALF_CYC))
                   ? PH_W'((int'(s_r.tx_pos) - HALF_CYC) * PH_ONE)
                   : PH_W'((int'(s_r.tx_pos) + HALF_CYC) * PH_ONE); // RULE6
        if (f_rise && (s_r.hold == '0))
        begin
          s_nxt.crs = 1'b1; // RULE5
          s_nxt.ovf = 1'b0;
          s_nxt.st = MCD_HUNT;
        end
      end
      MCD_HUNT:
      begin
        if (f_fall)
        begin
          s_nxt.st = MCD_GAP;
          s_nxt.acq = '0;
        end
      end
      MCD_GAP:
      begin
        if (s_r.acq != '1)
          s_nxt.acq = s_r.acq + 1'b1;
        if (f_fall && (s_r.acq >= CNT_W'(ACQ_GAP - 1 - ACQ_TOL))
            && (s_r.acq <= CNT_W'(ACQ_GAP - 1 + ACQ_TOL)))
        begin
          // Second zero centre two bits after the first: 1010 seen
          s_nxt.st = MCD_LOCK; // RULE5 RULE6
          s_nxt.ph = '0;
        end
        else if (f_fall)
          s_nxt.acq = '0;
        else if (s_r.acq > CNT_W'(ACQ_GAP - 1 + ACQ_TOL))
          s_nxt.st = MCD_HUNT;
      end
      MCD_LOCK:
      begin
        // Slow loop: one cell never pulls the phase far
        s_nxt.ph = PH_W'((ph_acc >= PH_WRAP) ? ph_acc - PH_WRAP : ph_acc); // RULE11
        if (tick)
          s_nxt.clk_en = 1'b1; // RULE7 RULE9
        if (tick && !fifo_in_ready)
          s_nxt.ovf = 1'b1;
      end
    endcase

    // End of message; overrides the state machine
    if (drop)
    begin
      s_nxt.crs = 1'b0; // RULE12 RULE13
      s_nxt.st = MCD_IDLE;
      s_nxt.clk_en = 1'b0;
      s_nxt.hold = CNT_W'(HOLD_CYC); // RULE14
    end

    // Recovered clock high from the quarter point for half a bit
    s_nxt.rclk = s_nxt.clk_en && (s_nxt.st == MCD_LOCK)
                 && ((ph_whole(s_nxt.ph) >= 5'(SAMP_CYC))
                 || (ph_whole(s_nxt.ph) < 5'(QTR_CYC))); // RULE7
    if (!s_nxt.crs)
      s_nxt.rdata = 1'b1; // RULE8
    else if (fifo_out_ready && fifo_out_valid)
      s_nxt.rdata = fifo_dout; // RULE9 RULE10
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.rdata <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign tx_diff.p = s_r.tx_p;
  assign tx_diff.n = s_r.tx_n;
  assign rx_out.rx_recovered_clock = s_r.rclk;
  assign rx_out.rx_recovered_data  = s_r.rdata;
  assign rx_out.rx_carrier_sense   = s_r.crs;
  assign rx_out.rx_overflow        = s_r.ovf;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] gap_cnt;
  logic             gap_seen;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gap_cnt <= '0;
      gap_seen <= 1'b0;
    end
    else if (bit_start)
    begin
      gap_cnt <= '0;
      gap_seen <= 1'b1;
    end
    else if (gap_cnt != '1)
      gap_cnt <= gap_cnt + 1'b1;
  end

  property p_bit_period;
    @(posedge clk) disable iff (rst)
    (bit_start && gap_seen) |-> (int'(gap_cnt) >= 2 * OSC_CYC - 2);
  endproperty
  a_bit_period: assert property (p_bit_period) // RULE1
    else $error("bit clock period shorter than two reference periods");

  property p_tx_latch;
    @(posedge clk) disable iff (rst)
    bit_start |=> (s_r.tx_bit == $past(tx_serial_data_in))
                  && (s_r.tx_act == $past(tx_request));
  endproperty
  a_tx_latch: assert property (p_tx_latch) // RULE2
    else $error("transmit inputs not registered at bit start");

  property p_tx_coded;
    @(posedge clk) disable iff (rst)
    s_r.tx_act |=> (tx_diff.n == !tx_diff.p);
  endproperty
  a_tx_coded: assert property (p_tx_coded) // RULE3
    else $error("active transmit pair not complementary");

  property p_tx_idle;
    @(posedge clk) disable iff (rst)
    !s_r.tx_act |=> (tx_diff.p == $past(tx_idle_select)) && !tx_diff.n;
  endproperty
  a_tx_idle: assert property (p_tx_idle) // RULE4
    else $error("idle level does not follow idle select");

  property p_lock_cause;
    @(posedge clk) disable iff (rst)
    (s_r.st != MCD_LOCK) ##1 (s_r.st == MCD_LOCK) |-> $past(s_r.st) == MCD_GAP
                                                     && s_r.crs && s_r.ph == '0;
  endproperty
  a_lock_cause: assert property (p_lock_cause) // RULE5
    else $error("lock entered without carrier and second zero");

  property p_clk_gate;
    @(posedge clk) disable iff (rst)
    (!s_r.clk_en && s_r.st != MCD_LOCK) |=> !rx_out.rx_recovered_clock;
  endproperty
  a_clk_gate: assert property (p_clk_gate) // RULE7
    else $error("recovered clock running before acquisition");

  property p_data_idle;
    @(posedge clk) disable iff (rst)
    !s_r.crs ##1 !s_r.crs |-> rx_out.rx_recovered_data;
  endproperty
  a_data_idle: assert property (p_data_idle) // RULE8
    else $error("recovered data not high while idle");

  property p_sample;
    @(posedge clk) disable iff (rst)
    tick |-> (ph_int == 5'(SAMP_CYC - 1)) && (s_r.st == MCD_LOCK);
  endproperty
  a_sample: assert property (p_sample) // RULE10
    else $error("sample taken away from the quarter point");

  property p_track_limit;
    @(posedge clk) disable iff (rst)
    cen_edge |-> (iabs(corr) * 10 <= iabs(err));
  endproperty
  a_track_limit: assert property (p_track_limit) // RULE11
    else $error("phase correction above one tenth of error");

  property p_crs_off;
    @(posedge clk) disable iff (rst)
    $fell(s_r.crs) |-> ($past(s_r.quiet) >= CNT_W'(BIT_CYC - 1))
                       && ($past(s_r.quiet) <= CNT_W'(2 * BIT_CYC - 1));
  endproperty
  a_crs_off: assert property (p_crs_off) // RULE12
    else $error("carrier dropped outside one to two bit times");

  property p_holdoff;
    @(posedge clk) disable iff (rst)
    $fell(s_r.crs) |-> (!s_r.crs && s_r.hold != '0) [*8];
  endproperty
  a_holdoff: assert property (p_holdoff) // RULE14
    else $error("carrier reasserted during hold-off");

endmodule

// ===== rtl/mcd_fifo.sv
// Small bit FIFO with valid/ready on both sides and a flush.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module mcd_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } mcd_fifo_st_t;

  mcd_fifo_st_t s_r;
  mcd_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Flush wins so nothing survives past the end of a frame
    if (flush)
    begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule

// ===== rtl/mcd_noise_filter.sv
// Pulse-width filter for the receive comparator output.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
module mcd_noise_filter #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw and filtered level
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       q;
  } mcd_nf_st_t;

  mcd_nf_st_t s_r;
  mcd_nf_st_t s_nxt;

  assign dout = s_r.q;

  // A level must hold N cycles before it passes; shorter spikes vanish
  always_comb
  begin
    s_nxt = s_r;
    if (din == s_r.q)
      s_nxt.cnt = '0;
    else if (s_r.cnt == 8'(N - 1))
    begin
      s_nxt.q = din; // RULE15
      s_nxt.cnt = '0;
    end
    else
      s_nxt.cnt = s_r.cnt + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule

// ===== shared/mcd_pkg.sv
// Constants and carriers for the Manchester codec block.
// Assumes a single 200 MHz clock and synchronous inputs sampled on it.
package mcd_pkg;

  // ----------------------------------------------------------------
  // Clock and bit timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 200;
  localparam int OSC_MHZ   = 20;
  localparam int DATA_MHZ  = 10;
  localparam int OSC_CYC   = CLK_MHZ / OSC_MHZ;
  localparam int BIT_CYC   = CLK_MHZ / DATA_MHZ;
  localparam int HALF_CYC  = BIT_CYC / 2;
  localparam int QTR_CYC   = BIT_CYC / 4;
  // Quarter bit into a cell, measured from the cell centre
  localparam int SAMP_CYC  = HALF_CYC + QTR_CYC;

  // ----------------------------------------------------------------
  // Receive timers, times in ns
  // ----------------------------------------------------------------
  localparam int CRS_OFF_NS  = 150;
  localparam int CRS_OFF_CYC = (CRS_OFF_NS * CLK_MHZ) / 1000;
  localparam int HOLD_NS     = 200;
  localparam int HOLD_CYC    = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int NOISE_NS    = 15;
  localparam int NOISE_CYC   = (NOISE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ_GAP     = 2 * BIT_CYC;
  localparam int ACQ_TOL     = QTR_CYC - 1;

  // ----------------------------------------------------------------
  // Phase accumulator, fixed point with PH_FB fraction bits
  // ----------------------------------------------------------------
  localparam int PH_FB      = 4;
  localparam int PH_ONE     = 1 << PH_FB;
  localparam int PH_WRAP    = BIT_CYC * PH_ONE;
  localparam int PH_W       = 9;
  localparam int TRK_WIN    = (QTR_CYC - 1) * PH_ONE;
  localparam int CORR_MUL   = 3;
  localparam int CORR_SH    = 5;
  localparam int CNT_W      = 7;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {MCD_IDLE, MCD_HUNT, MCD_GAP, MCD_LOCK} mcd_rx_st_t;

  typedef struct packed {
    logic p;
    logic n;
  } mcd_tx_diff_t;

  typedef struct packed {
    logic rx_recovered_clock;
    logic rx_recovered_data;
    logic rx_carrier_sense;
    logic rx_overflow;
  } mcd_rx_out_t;

endpackage

// ===== test/mcd_mau_model.sv
// Medium-side model: drives Manchester frames onto the receive comparator line.
// Assumes the codec clock; frames go MSB first, 20 cycles a bit, on request.
`timescale 1ns/1ps
module mcd_mau_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Frame request
  input  wire logic        go,
  input  wire logic [63:0] frame,
  input  wire logic [6:0]  len,
  output logic             busy,
  // Medium
  output logic             rx_diff_in
);
  logic [63:0] sh_r;
  logic [6:0]  left_r;
  logic [4:0]  cyc_r;

  initial
  begin
    busy = 1'b0;
    rx_diff_in = 1'b0;
  end

  // ---------------------------------------------------------------
  // Line driver
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst || !busy)
    begin
      // Released pair chatters every cycle, too short to pass a filter
      rx_diff_in <= ~rx_diff_in;
      cyc_r      <= 5'h00;
      busy       <= go && !rst;
      sh_r       <= frame << (7'h40 - len);
      left_r     <= len;
    end
    else
    begin
      rx_diff_in <= (cyc_r < 5'h0a) ? ~sh_r[63] : sh_r[63];
      cyc_r      <= (cyc_r == 5'h13) ? 5'h00 : cyc_r + 5'h01;
      if (cyc_r == 5'h13)
      begin
        sh_r   <= sh_r << 1;
        left_r <= left_r - 7'h01;
        busy   <= left_r != 7'h01;
      end
    end
  end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the Manchester codec: transmit rows, then receive cases.
// Assumes the medium model on the receive line and a 200 MHz clock.
`timescale 1ns/1ps
module testbench;
  import mcd_pkg::*;

  typedef struct packed {
    logic        sel;
    logic [7:0]  bits;
    logic [15:0] halves;
    logic [1:0]  idle;
  } mcd_tb_row_t;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         osc_input = 1'b0;
  logic [3:0]   osc_cnt = 4'h0;
  logic         tx_idle_select = 1'b0;
  logic         tx_serial_data_in = 1'b0;
  logic         tx_request = 1'b0;
  logic         rx_ready = 1'b1;
  logic         rx_diff_in;
  logic         go = 1'b0;
  logic [63:0]  frame = 64'h0;
  logic [6:0]   len = 7'h00;
  logic         busy;
  mcd_rx_out_t  rx_out;
  mcd_tx_diff_t tx_diff;
  int           errors = 0;
  int           checks_done = 0;
  // Half-cell levels of p, first half first
  mcd_tb_row_t  rows [3] = '{
    '{1'b0, 8'hab, 16'h6665, 2'b00},
    '{1'b1, 8'h81, 16'h6aa9, 2'b10},
    '{1'b0, 8'hff, 16'h5555, 2'b00}};

  always #2.5 clk = ~clk;

  // 20 MHz reference: ten clk cycles a period
  always @(posedge clk)
  begin
    osc_cnt   <= (osc_cnt == 4'h9) ? 4'h0 : osc_cnt + 4'h1;
    osc_input <= osc_cnt < 4'h5;
  end

  mcd_codec #(.NOISE_W(NOISE_CYC), .DEPTH(FIFO_DEPTH)) DUT (
    .clk(clk), .rst(rst), .osc_input(osc_input), .tx_idle_select(tx_idle_select),
    .tx_serial_data_in(tx_serial_data_in), .tx_request(tx_request),
    .rx_ready(rx_ready), .rx_out(rx_out), .rx_diff_in(rx_diff_in), .tx_diff(tx_diff));

  mcd_mau_model MAU (
    .clk(clk), .rst(rst), .go(go), .frame(frame), .len(len), .busy(busy),
    .rx_diff_in(rx_diff_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Sends one frame and watches carrier, recovered clock and data
  task automatic run_rx(input logic [63:0] f, input logic [6:0] n, input logic rdy,
                        input bit full);
    int   nn;
    int   t_clk;
    int   t_end;
    int   t_crs;
    int   t_drop;
    logic prev;
    logic q[$];
    nn = n;
    t_clk = -1;
    t_end = -1;
    t_crs = -1;
    t_drop = -1;
    prev = 1'b0;
    @(posedge clk);
    frame    <= f;
    len      <= n;
    go       <= 1'b1;
    rx_ready <= rdy;
    @(posedge clk);
    go <= 1'b0;
    for (int t = 0; t < 2000 && t_drop < 0; t++)
    begin
      @(negedge clk);
      if (rx_out.rx_recovered_clock === 1'b1 && prev === 1'b0)
      begin
        if (t_clk < 0)
          t_clk = t;
        q.push_back(rx_out.rx_recovered_data);
      end
      prev = rx_out.rx_recovered_clock;
      if (busy === 1'b0 && t_end < 0 && t > 5)
        t_end = t;
      if (rx_out.rx_carrier_sense === 1'b1 && t_crs < 0)
        t_crs = t;
      if (rx_out.rx_carrier_sense === 1'b0 && t_crs >= 0)
        t_drop = t;
    end
    if (full)
    begin
      check({3'b000, t_crs >= 10 && t_crs <= 25}, 4'h1, "carrier on");
      check({3'b000, t_clk >= 84 && t_clk <= 100}, 4'h1, "first rx clock");
      check(4'(q.size()), 4'(nn - 3), "bit count");
      for (int i = 1; i < q.size() && i <= nn - 4; i++)
        check({3'b000, q[i]}, {3'b000, f[nn-4-i]}, "rx bit");
    end
    else
      check({3'b000, t_crs >= 38}, 4'h1, "carrier hold-off");
    check({3'b000, t_drop - t_end >= 10 && t_drop - t_end <= 30}, 4'h1, "carrier off");
    check({1'b0, rx_out[3:1]}, 4'b0010, "idle after frame");
    $display("test receive frame of %0d bits done", nn);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (11) @(posedge clk);
    @(negedge clk);
    check({2'b00, tx_diff}, 4'h0, "reset tx");
    check(rx_out, 4'b0100, "reset rx");
    @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(negedge clk);
    check(rx_out, 4'b0100, "idle with line noise");
    check({2'b00, tx_diff}, 4'h0, "idle tx");
    $display("test reset done");
    foreach (rows[r])
    begin
      @(posedge clk);
      tx_idle_select    <= rows[r].sel;
      tx_request        <= 1'b1;
      tx_serial_data_in <= rows[r].bits[7];
      @(negedge clk);
      for (int i = 0; i < 60 && tx_diff !== 2'b01; i++)
        @(negedge clk);
      // Each step lands mid half-cell; data changes well clear of bit start
      for (int k = 0; k < 16; k++)
      begin
        repeat (k == 0 ? 5 : 10) @(posedge clk);
        if (k % 2 == 0 && k < 14)
          tx_serial_data_in <= rows[r].bits[6-k/2];
        if (k == 15)
          tx_request <= 1'b0;
        @(negedge clk);
        check({2'b00, tx_diff}, {2'b00, rows[r].halves[15-k], ~rows[r].halves[15-k]},
              "tx half");
      end
      repeat (10) @(posedge clk);
      @(negedge clk);
      check({2'b00, tx_diff}, {2'b00, rows[r].idle}, "tx idle level");
      $display("test transmit row %0d done", r);
    end
    run_rx(64'hab2d, 7'd16, 1'b1, 1'b1);
    run_rx(64'haaaaaaab, 7'd32, 1'b0, 1'b0);
    check({3'b000, rx_out.rx_overflow}, 4'h1, "overflow set");
    repeat (60) @(negedge clk);
    check({3'b000, rx_out.rx_overflow}, 4'h1, "overflow sticky");
    run_rx(64'hab2d, 7'd16, 1'b1, 1'b1);
    check({3'b000, rx_out.rx_overflow}, 4'h0, "overflow cleared");
    print_verdict();
  end

  // Whole run is near 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
